// File: hdl/dsg_clock_gate_bank.sv
// deep-sleep peripheral clock gating register with apb access,
// effective enable selection and bus fault for unclocked peripherals
// assumes one 100 mhz clock; run/sleep words come from sibling logic
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module dsg_clock_gate_bank (
  input  wire logic                i_clk_sys,
  input  wire logic                i_sys_rst,
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [11:0]         i_paddr,
  input  wire logic [31:0]         i_pwdata,
  output logic      [31:0]         o_prdata,
  output logic                     o_pready,
  output logic                     o_pslverr,
  input  wire dsg_pkg::dsg_mode_t  i_power_mode,
  input  wire logic                i_auto_clock_gating_select,
  input  wire logic [31:0]         i_run_peripheral_clock_gate,
  input  wire logic [31:0]         i_sleep_peripheral_clock_gate,
  input  wire dsg_pkg::dsg_access_t i_periph_access,
  output logic      [31:0]         o_periph_clk_en,
  output logic                     o_periph_bus_fault
);

  logic [31:0] deep_gate_reg;
  logic [31:0] deep_gate_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        fault_reg;
  logic        fault_next;
  logic        setup_ph;
  logic        access_ph;
  logic        hit_deep;
  logic        hit_eff;
  logic        mapped;

  // address decode; only the two words of this block answer
  assign setup_ph  = i_psel && !i_penable;
  assign access_ph = i_psel && i_penable;
  assign hit_deep  = (i_paddr == dsg_pkg::DEEP_GATE_OFS);
  assign hit_eff   = (i_paddr == dsg_pkg::EFF_GATE_OFS);
  assign mapped    = hit_deep || hit_eff;

  // zero wait states: read data is staged in the setup cycle
  assign o_pready  = 1'h1;
  assign o_pslverr = access_ph && !mapped;

  // deep-sleep word: only implemented bits store, reserved stay zero
  always_comb begin
    deep_gate_next = deep_gate_reg;
    if (access_ph && i_pwrite && hit_deep) begin
      deep_gate_next = i_pwdata & dsg_pkg::GATE_IMPL_MASK;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      deep_gate_reg <= dsg_pkg::DEEP_GATE_RST;
    end else begin
      deep_gate_reg <= deep_gate_next;
    end
  end

  // read mux; the effective word lets software see what is clocked now
  always_comb begin
    prdata_next = prdata_reg;
    if (setup_ph && !i_pwrite) begin
      if (hit_deep) begin
        prdata_next = deep_gate_reg & dsg_pkg::GATE_IMPL_MASK;
      end else if (hit_eff) begin
        prdata_next = o_periph_clk_en;
      end else begin
        prdata_next = dsg_pkg::ZERO_WORD;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prdata_reg <= dsg_pkg::ZERO_WORD;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign o_prdata = prdata_reg;

  // mode selection and the registered enables
  dsg_gate_select u_sel (
    .i_clk_sys                  (i_clk_sys),
    .i_sys_rst                  (i_sys_rst),
    .i_power_mode               (i_power_mode),
    .i_auto_clock_gating_select (i_auto_clock_gating_select),
    .i_run_gate                 (i_run_peripheral_clock_gate),
    .i_sleep_gate               (i_sleep_peripheral_clock_gate),
    .i_deep_gate                (deep_gate_reg),
    .o_clk_en                   (o_periph_clk_en)
  );

  // fault when the addressed peripheral has no clock; an index with no
  // peripheral behind it always faults since its enable is forced low
  always_comb begin
    fault_next = i_periph_access.valid && !o_periph_clk_en[i_periph_access.idx];
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fault_reg <= 1'h0;
    end else begin
      fault_reg <= fault_next;
    end
  end

  assign o_periph_bus_fault = fault_reg;

  // checks on the gating word, the enables and the fault answer
  property p_rst_clear;
    @(posedge i_clk_sys) $fell(i_sys_rst) |-> (deep_gate_reg == dsg_pkg::DEEP_GATE_RST);
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("gate word not clear after reset");

  property p_write_store;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (access_ph && i_pwrite && hit_deep)
      |=> (deep_gate_reg == ($past(i_pwdata) & dsg_pkg::GATE_IMPL_MASK));
  endproperty
  a_write_store: assert property (p_write_store)
    else $error("gate write not stored");

  property p_resv_read;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (access_ph && !i_pwrite && hit_deep) |-> ((o_prdata & ~dsg_pkg::GATE_IMPL_MASK) == 32'h0);
  endproperty
  a_resv_read: assert property (p_resv_read)
    else $error("reserved bit read nonzero");

  property p_read_back;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (setup_ph && !i_pwrite && hit_deep) |=> (o_prdata == $past(deep_gate_reg));
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("gate word read back wrong");

  property p_decode;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      access_ph |-> (o_pslverr == !(i_paddr == dsg_pkg::DEEP_GATE_OFS
                                    || i_paddr == dsg_pkg::EFF_GATE_OFS));
  endproperty
  a_decode: assert property (p_decode)
    else $error("address decode wrong");

  property p_no_ghost;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      ((o_periph_clk_en & ~dsg_pkg::GATE_IMPL_MASK) == 32'h0);
  endproperty
  a_no_ghost: assert property (p_no_ghost)
    else $error("enable on empty position");

  property p_deep_sel;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_auto_clock_gating_select && i_power_mode == dsg_pkg::DSG_DEEP)
      |=> (o_periph_clk_en == ($past(deep_gate_reg) & dsg_pkg::GATE_IMPL_MASK));
  endproperty
  a_deep_sel: assert property (p_deep_sel)
    else $error("deep word not selected");

  property p_manual_run;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      !i_auto_clock_gating_select
      |=> (o_periph_clk_en == ($past(i_run_peripheral_clock_gate) & dsg_pkg::GATE_IMPL_MASK));
  endproperty
  a_manual_run: assert property (p_manual_run)
    else $error("run word not used");

  property p_fault_off;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_periph_access.valid && !o_periph_clk_en[i_periph_access.idx])
      |=> o_periph_bus_fault;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("missing bus fault");

  property p_no_fault_on;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (!i_periph_access.valid || o_periph_clk_en[i_periph_access.idx])
      |=> !o_periph_bus_fault;
  endproperty
  a_no_fault_on: assert property (p_no_fault_on)
    else $error("fault on clocked unit");

  property p_deep_write_reach;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (access_ph && i_pwrite && hit_deep && i_auto_clock_gating_select
       && i_power_mode == dsg_pkg::DSG_DEEP) ##1 (i_power_mode == dsg_pkg::DSG_DEEP
       && i_auto_clock_gating_select)
      |=> (o_periph_clk_en == ($past(i_pwdata, 2) & dsg_pkg::GATE_IMPL_MASK));
  endproperty
  a_deep_write_reach: assert property (p_deep_write_reach)
    else $error("write not on enables");

  // main scenarios
  property p_cov_deep;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      i_auto_clock_gating_select && i_power_mode == dsg_pkg::DSG_DEEP && (o_periph_clk_en != 32'h0);
  endproperty
  c_cov_deep: cover property (p_cov_deep);

  property p_cov_fault;
    @(posedge i_clk_sys) disable iff (i_sys_rst) o_periph_bus_fault;
  endproperty
  c_cov_fault: cover property (p_cov_fault);

  property p_cov_err;
    @(posedge i_clk_sys) disable iff (i_sys_rst) o_pslverr;
  endproperty
  c_cov_err: cover property (p_cov_err);

endmodule

// File: hdl/dsg_gate_select.sv
// picks the gating word that applies in the present mode and registers it
// assumes mode, auto select and the run/sleep words come from the same clock
`timescale 1ns/1ps
module dsg_gate_select (
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  input  wire dsg_pkg::dsg_mode_t i_power_mode,
  input  wire logic              i_auto_clock_gating_select,
  input  wire logic [31:0]       i_run_gate,
  input  wire logic [31:0]       i_sleep_gate,
  input  wire logic [31:0]       i_deep_gate,
  output logic      [31:0]       o_clk_en
);

  logic [31:0] clk_en_reg;
  logic [31:0] clk_en_next;

  // sleep words only count with auto gating on; otherwise run word holds
  always_comb begin
    clk_en_next = i_run_gate;
    if (i_auto_clock_gating_select) begin
      case (i_power_mode)
        dsg_pkg::DSG_RUN:   clk_en_next = i_run_gate;
        dsg_pkg::DSG_SLEEP: clk_en_next = i_sleep_gate;
        dsg_pkg::DSG_DEEP:  clk_en_next = i_deep_gate;
        default:            clk_en_next = i_run_gate;
      endcase
    end
    clk_en_next = clk_en_next & dsg_pkg::GATE_IMPL_MASK;
  end

  // registered so the enables never glitch when the mode word changes
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      clk_en_reg <= dsg_pkg::DEEP_GATE_RST;
    end else begin
      clk_en_reg <= clk_en_next;
    end
  end

  assign o_clk_en = clk_en_reg;

endmodule

// File: shared/dsg_pkg.sv
// constants and types for the deep-sleep peripheral clock gating bank
// assumes a 32-bit apb slave decoding only the low 12 address bits
package dsg_pkg;

  // register map, byte addresses inside the system control block
  localparam logic [31:0] SYS_CTRL_BASE = 32'h400F_E000;
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] DEEP_GATE_OFS = 12'h124;
  localparam logic [11:0] EFF_GATE_OFS  = 12'h128;
  localparam logic [31:0] DEEP_GATE_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // gating bit positions, one per peripheral
  localparam int COMPARATOR_2_GATE_BIT        = 26;
  localparam int COMPARATOR_1_GATE_BIT        = 25;
  localparam int COMPARATOR_0_GATE_BIT        = 24;
  localparam int GP_COUNTER_3_GATE_BIT        = 19;
  localparam int GP_COUNTER_2_GATE_BIT        = 18;
  localparam int GP_COUNTER_1_GATE_BIT        = 17;
  localparam int GP_COUNTER_0_GATE_BIT        = 16;
  localparam int TWO_WIRE_PORT_1_GATE_BIT     = 14;
  localparam int TWO_WIRE_PORT_0_GATE_BIT     = 12;
  localparam int QUADRATURE_DECODER_1_GATE_BIT = 9;
  localparam int QUADRATURE_DECODER_0_GATE_BIT = 8;
  localparam int SYNC_SERIAL_1_GATE_BIT       = 5;
  localparam int SYNC_SERIAL_0_GATE_BIT       = 4;
  localparam int ASYNC_SERIAL_2_GATE_BIT      = 2;
  localparam int ASYNC_SERIAL_1_GATE_BIT      = 1;
  localparam int ASYNC_SERIAL_0_GATE_BIT      = 0;

  // implemented read/write bits; everything else is reserved, reads zero
  localparam logic [31:0] GATE_IMPL_MASK =
    (32'h1 << COMPARATOR_2_GATE_BIT) | (32'h1 << COMPARATOR_1_GATE_BIT) |
    (32'h1 << COMPARATOR_0_GATE_BIT) | (32'h1 << GP_COUNTER_3_GATE_BIT) |
    (32'h1 << GP_COUNTER_2_GATE_BIT) | (32'h1 << GP_COUNTER_1_GATE_BIT) |
    (32'h1 << GP_COUNTER_0_GATE_BIT) | (32'h1 << TWO_WIRE_PORT_1_GATE_BIT) |
    (32'h1 << TWO_WIRE_PORT_0_GATE_BIT) | (32'h1 << QUADRATURE_DECODER_1_GATE_BIT) |
    (32'h1 << QUADRATURE_DECODER_0_GATE_BIT) | (32'h1 << SYNC_SERIAL_1_GATE_BIT) |
    (32'h1 << SYNC_SERIAL_0_GATE_BIT) | (32'h1 << ASYNC_SERIAL_2_GATE_BIT) |
    (32'h1 << ASYNC_SERIAL_1_GATE_BIT) | (32'h1 << ASYNC_SERIAL_0_GATE_BIT);

  // operating mode of the chip, driven by the power controller
  typedef enum logic [1:0] {
    DSG_RUN   = 2'b00,
    DSG_SLEEP = 2'b01,
    DSG_DEEP  = 2'b10
  } dsg_mode_t;

  localparam int PERIPH_IDX_W = 5;

  // one bus access aimed at a gated peripheral, index is its gating bit
  typedef struct packed {
    logic                    valid;
    logic [PERIPH_IDX_W-1:0] idx;
  } dsg_access_t;

endpackage

// File: test/dsg_clock_gate_bank_tb_top.sv
// self-checking bench for the deep-sleep clock gating bank
// assumes the bank answers apb itself; the bench drives every port directly
`timescale 1ns/1ps
module dsg_clock_gate_bank_tb_top;
  localparam logic [31:0] MASK = 32'h070F_5337; // implemented gating bits
  logic                 i_clk_sys, i_sys_rst, i_psel, i_penable, i_pwrite, i_auto;
  logic [11:0]          i_paddr;
  logic [31:0]          i_pwdata, o_prdata, o_periph_clk_en, run_w, slp_w, rd, exp_en;
  logic                 o_pready, o_pslverr, o_periph_bus_fault, err;
  dsg_pkg::dsg_mode_t   i_mode;
  dsg_pkg::dsg_access_t i_acc;
  int                   n_mismatch = 0;
  int                   check_count = 0;
  int                   cyc = 0;

  dsg_clock_gate_bank dsg_clock_gate_bank_i (
    .i_clk_sys                     (i_clk_sys),
    .i_sys_rst                     (i_sys_rst),
    .i_psel                        (i_psel),
    .i_penable                     (i_penable),
    .i_pwrite                      (i_pwrite),
    .i_paddr                       (i_paddr),
    .i_pwdata                      (i_pwdata),
    .o_prdata                      (o_prdata),
    .o_pready                      (o_pready),
    .o_pslverr                     (o_pslverr),
    .i_power_mode                  (i_mode),
    .i_auto_clock_gating_select    (i_auto),
    .i_run_peripheral_clock_gate   (run_w),
    .i_sleep_peripheral_clock_gate (slp_w),
    .i_periph_access               (i_acc),
    .o_periph_clk_en               (o_periph_clk_en),
    .o_periph_bus_fault            (o_periph_bus_fault)
  );

  // free-running system clock
  initial begin
    i_clk_sys = 1'h0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // hang guard, far above the under two hundred cycles the tests need
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%08h expected=%08h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_psel    <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'h1;
    do @(posedge i_clk_sys); while (o_pready !== 1'h1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'h0;
    i_penable <= 1'h0;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd_reg(input logic [11:0] a);
    apb(1'h0, a, 32'h0);
  endtask

  // enables are registered, so allow two edges after the inputs land
  task automatic chk_en(input dsg_pkg::dsg_mode_t m, input logic au, input logic [31:0] w);
    @(posedge i_clk_sys);
    i_mode <= m;
    i_auto <= au;
    repeat (2) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk(o_periph_clk_en, w & MASK);
  endtask

  // one access to peripheral idx; fault pulse only when its clock is off
  task automatic chk_fault(input logic [4:0] idx);
    @(posedge i_clk_sys);
    i_acc <= '{valid: 1'h1, idx: idx};
    @(posedge i_clk_sys);
    i_acc <= '{valid: 1'h0, idx: 5'h00};
    @(negedge i_clk_sys);
    chk({31'h0, o_periph_bus_fault}, {31'h0, ~exp_en[idx]});
    @(negedge i_clk_sys);
    chk({31'h0, o_periph_bus_fault}, 32'h0);
  endtask

  initial begin
    i_sys_rst = 1'h1;
    i_psel    = 1'h0;
    i_penable = 1'h0;
    i_pwrite  = 1'h0;
    i_paddr   = 12'h000;
    i_pwdata  = 32'h0;
    i_mode    = dsg_pkg::DSG_DEEP;
    i_auto    = 1'h1;
    i_acc     = '{valid: 1'h0, idx: 5'h00};
    run_w     = 32'hFFFF_00F0;
    slp_w     = 32'h0F00_FF0F;
    repeat (10) @(posedge i_clk_sys);
    i_sys_rst <= 1'h0;
    // everything comes up unclocked
    rd_reg(12'h124);
    chk(rd, 32'h0);
    @(negedge i_clk_sys);
    chk(o_periph_clk_en, 32'h0);
    chk({31'h0, o_pready}, 32'h1);
    $display("test reset done");
    // all ones: only the implemented bits stick, reserved read zero
    wr_reg(12'h124, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h0);
    rd_reg(12'h124);
    chk(rd, MASK);
    wr_reg(12'h124, 32'h0);
    rd_reg(12'h124);
    chk(rd, 32'h0);
    $display("test field map done");
    // unmapped word is refused and leaves the gating word alone
    wr_reg(12'h12C, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1);
    rd_reg(12'h124);
    chk(rd, 32'h0);
    // the effective word only reads: a write there is taken without error, stores nothing
    wr_reg(12'h128, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h0);
    rd_reg(12'h124);
    chk(rd, 32'h0);
    // software style read-modify-write keeps whatever reserved bits read
    rd_reg(12'h124);
    wr_reg(12'h124, rd | 32'h0000_0010);
    rd_reg(12'h124);
    chk(rd, 32'h0000_0010);
    $display("test access done");
    // mode and auto select pick the word that gates the clocks
    exp_en = 32'hA5A5_5A5A & MASK;
    wr_reg(12'h124, 32'hA5A5_5A5A);
    chk_en(dsg_pkg::DSG_DEEP, 1'h1, exp_en);
    chk_en(dsg_pkg::DSG_SLEEP, 1'h1, slp_w);
    chk_en(dsg_pkg::DSG_RUN, 1'h1, run_w);
    chk_en(dsg_pkg::dsg_mode_t'(2'h3), 1'h1, run_w);
    chk_en(dsg_pkg::DSG_DEEP, 1'h0, run_w);
    chk_en(dsg_pkg::DSG_SLEEP, 1'h0, run_w);
    chk_en(dsg_pkg::DSG_DEEP, 1'h1, exp_en);
    rd_reg(12'h128);
    chk(rd, exp_en);
    $display("test mode select done");
    // every peripheral index, gated ones must fault
    for (int i = 0; i < 32; i++) begin
      chk_fault(i[4:0]);
    end
    $display("test bus fault done");
    give_verdict();
  end
endmodule
